//--- verilog/drs_pkg.sv
// Package for the DMA request steering glue.
// Assumes a single 20 MHz host bus clock domain.
package drs_pkg;
    // ****************************************************
    // Request sources
    // ****************************************************
    localparam int DRS_NSRC       = 6;
    localparam int SRC_DSC_RX     = 0;
    localparam int SRC_DSC_TX     = 1;
    localparam int SRC_USA_RX     = 2;
    localparam int SRC_USA_TX     = 3;
    localparam int SRC_USB_RX     = 4;
    localparam int SRC_USB_TX     = 5;
    localparam logic [5:0] DRS_REQ_IDLE = 6'h3F;
    localparam logic [1:0] DRS_CON_IDLE = 2'h3;

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0] {
        DRS_TXS_DIRECT  = 2'h0,
        DRS_TXS_CLIPPED = 2'h1,
        DRS_TXS_OFF     = 2'h2
    } drs_txsel_t;

    typedef struct packed {
        logic [5:0] en_ch_zero;
        logic [5:0] en_ch_one;
        drs_txsel_t dsc_tx_sel;
    } drs_steer_t;

    typedef struct packed {
        logic dma_request_ch_zero;
        logic dma_request_ch_one;
    } drs_req_t;
endpackage

//--- verilog/drs_glue.sv
// DMA request steering glue logic for the host board.
// Assumes all inputs synchronous to i_clk_sys; steering comes from straps.
`timescale 1ns/1ps
`default_nettype none
module drs_glue
    import drs_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic [5:0] i_src_req_n,
    input  wire drs_steer_t i_steer,
    input  wire logic       i_int_ack_n,
    input  wire logic       i_bus_hold_req,
    input  wire logic       i_bus_hold_grant,
    input  wire logic       i_midrange_select_two_n,
    input  wire logic       i_mem_sel_n,
    input  wire logic       i_term_rxd,
    input  wire logic       i_con_txd,
    input  wire logic       i_int_chain_req_n,
    output logic            o_dma_request_ch_zero,
    output logic            o_dma_request_ch_one,
    output logic            o_ctrl_reset_n,
    output logic            o_ram_sel_n,
    output logic            o_nmi,
    output logic            o_host_int,
    output logic            o_hold_req
);
    // ****************************************************
    // Input sampling
    // ****************************************************
    logic [5:0] req_n_r;
    logic       dsc_tx_prev_r;
    logic       iack_n_r;
    logic [1:0] term_r;
    logic [1:0] con_r;
    logic       con_seen_r;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            req_n_r       <= DRS_REQ_IDLE;
            dsc_tx_prev_r <= 1'b1;
            iack_n_r      <= 1'b1;
        end else begin
            req_n_r       <= i_src_req_n;
            dsc_tx_prev_r <= req_n_r[SRC_DSC_TX];
            iack_n_r      <= i_int_ack_n;
        end
    end

    // ****************************************************
    // Decode helpers
    // ****************************************************
    // True when any active-low source enabled by the mask is low
    function automatic logic any_enabled(
        input logic [5:0] req_n,
        input logic [5:0] mask
    );
        any_enabled = |(~req_n & mask);
    endfunction

    // High to low step seen by a two-stage line sampler
    function automatic logic fell_edge(input logic [1:0] smp);
        fell_edge = (smp == 2'h2);
    endfunction

    // ****************************************************
    // Request combining
    // ****************************************************
    // Clipped request: held only on the first sampled low cycle, so an
    // older controller that releases late cannot cause an extra transfer.
    logic     clip_tx;
    logic     ch0_any;
    logic     ch1_any;
    logic     ch1_dsc;
    drs_req_t req_nxt;

    always_comb begin
        clip_tx = ~req_n_r[SRC_DSC_TX] & dsc_tx_prev_r;
        ch0_any = any_enabled(req_n_r, i_steer.en_ch_zero);
        case (i_steer.dsc_tx_sel)
            DRS_TXS_DIRECT:  ch1_dsc = ~req_n_r[SRC_DSC_TX];
            DRS_TXS_CLIPPED: ch1_dsc = clip_tx;
            DRS_TXS_OFF:     ch1_dsc = 1'b0;
            default:         ch1_dsc = 1'b0;
        endcase
        // Transmit source of the dual controller reaches channel one
        // only via the selector above.
        ch1_any = ch1_dsc
                | |(~req_n_r & i_steer.en_ch_one
                    & ~(6'h01 << SRC_DSC_TX));
        req_nxt.dma_request_ch_zero = ch0_any & iack_n_r;
        req_nxt.dma_request_ch_one  = ch1_any & iack_n_r;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_dma_request_ch_zero <= 1'b0;
            o_dma_request_ch_one  <= 1'b0;
        end else begin
            o_dma_request_ch_zero <= req_nxt.dma_request_ch_zero;
            o_dma_request_ch_one  <= req_nxt.dma_request_ch_one;
        end
    end

    // ****************************************************
    // Bus hold, memory select, controller reset, interrupts
    // ****************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_hold_req     <= 1'b0;
            o_ram_sel_n    <= 1'b1;
            o_ctrl_reset_n <= 1'b0;
            o_host_int     <= 1'b0;
        end else begin
            o_hold_req     <= i_bus_hold_req;
            o_ram_sel_n    <= i_mem_sel_n;
            o_ctrl_reset_n <= i_midrange_select_two_n;
            o_host_int     <= ~i_int_chain_req_n;
        end
    end

    // ****************************************************
    // Start bit detection for the non-maskable interrupt
    // ****************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            term_r     <= DRS_CON_IDLE;
            con_r      <= DRS_CON_IDLE;
            con_seen_r <= 1'b0;
            o_nmi      <= 1'b0;
        end else begin
            term_r <= {term_r[0], i_term_rxd};
            con_r  <= {con_r[0], i_con_txd};
            if (fell_edge(con_r)) begin
                con_seen_r <= 1'b1;
            end
            o_nmi <= fell_edge(term_r)
                   | (fell_edge(con_r) & ~con_seen_r);
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    // ****************************************************
    // Request checks
    // ****************************************************
    a_iack_blocks_req: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !iack_n_r |=> !o_dma_request_ch_zero && !o_dma_request_ch_one)
        else $error("request during iack");
    a_ch0_iack_gate: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_dma_request_ch_zero |-> $past(iack_n_r))
        else $error("ch0 high after iack");
    a_ch1_iack_gate: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_dma_request_ch_one |-> $past(iack_n_r))
        else $error("ch1 high after iack");
    a_ch0_source_low: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_dma_request_ch_zero
        |-> $past(any_enabled(req_n_r, i_steer.en_ch_zero)))
        else $error("ch0 without source");
    a_req_sampled: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        1'b1 |=> req_n_r == $past(i_src_req_n))
        else $error("requests not sampled");
    a_iack_sampled: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        1'b1 |=> iack_n_r == $past(i_int_ack_n))
        else $error("iack not sampled");
    a_ch0_follows_src: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        any_enabled(req_n_r, i_steer.en_ch_zero) && iack_n_r
        |=> o_dma_request_ch_zero) else $error("ch0 missed");
    a_ch0_release: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !any_enabled(req_n_r, i_steer.en_ch_zero)
        |=> !o_dma_request_ch_zero) else $error("ch0 stuck");
    a_ch1_follows_src: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        ch1_any && iack_n_r |=> o_dma_request_ch_one)
        else $error("ch1 missed");
    a_ch1_release: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !ch1_any |=> !o_dma_request_ch_one)
        else $error("ch1 stuck");

    // ****************************************************
    // Steering checks
    // ****************************************************
    a_tx_prev_tracks: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        1'b1 |=> dsc_tx_prev_r == $past(req_n_r[SRC_DSC_TX]))
        else $error("tx history lost");
    a_clip_no_repeat: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        clip_tx |=> !clip_tx)
        else $error("clip repeated");
    a_clip_one_cycle: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) i_steer.dsc_tx_sel == DRS_TXS_CLIPPED
        && $stable(i_steer) && i_steer.en_ch_one == 6'h00 && clip_tx
        |=> ##1 !o_dma_request_ch_one) else $error("clip long");
    a_clip_first_cycle: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_steer.dsc_tx_sel == DRS_TXS_CLIPPED && clip_tx && iack_n_r
        |=> o_dma_request_ch_one) else $error("clip missed");
    a_direct_tx: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) i_steer.dsc_tx_sel == DRS_TXS_DIRECT
        && !req_n_r[SRC_DSC_TX] && iack_n_r
        |=> o_dma_request_ch_one) else $error("direct tx missed");
    a_tx_off_quiet: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) i_steer.dsc_tx_sel == DRS_TXS_OFF
        && i_steer.en_ch_one == 6'h00
        |=> !o_dma_request_ch_one) else $error("tx off leaked");

    // ****************************************************
    // Pass-through checks
    // ****************************************************
    a_hold_pass: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_bus_hold_req |=> o_hold_req)
        else $error("hold lost");
    a_hold_drop: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_bus_hold_req |=> !o_hold_req)
        else $error("hold stuck");
    a_ram_sel: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_mem_sel_n |=> !o_ram_sel_n)
        else $error("ram select lost");
    a_ram_idle: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_mem_sel_n |=> o_ram_sel_n)
        else $error("ram select stuck");
    a_reset_follows: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_midrange_select_two_n |=> !o_ctrl_reset_n)
        else $error("ctrl reset missed");
    a_reset_release: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_midrange_select_two_n |=> o_ctrl_reset_n)
        else $error("ctrl reset stuck");
    a_chain_int: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_int_chain_req_n |=> o_host_int)
        else $error("chain int lost");
    a_chain_idle: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_int_chain_req_n |=> !o_host_int)
        else $error("chain int stuck");

    // ****************************************************
    // Start bit checks
    // ****************************************************
    a_term_sampled: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        1'b1 |=> term_r[0] == $past(i_term_rxd))
        else $error("terminal line not sampled");
    a_con_sampled: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        1'b1 |=> con_r[0] == $past(i_con_txd))
        else $error("console line not sampled");
    a_term_nmi: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        fell_edge(term_r) |=> o_nmi)
        else $error("nmi missed");
    a_nmi_cause: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_nmi |-> $past(fell_edge(term_r) || fell_edge(con_r)))
        else $error("nmi without start bit");
    a_nmi_quiet: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !fell_edge(term_r) && !fell_edge(con_r) |=> !o_nmi)
        else $error("spurious nmi");
    a_con_first_nmi: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        fell_edge(con_r) && !con_seen_r |=> o_nmi)
        else $error("console nmi missed");
    a_con_marks_seen: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        fell_edge(con_r) |=> con_seen_r)
        else $error("console not marked");
    a_con_seen_sticky: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        con_seen_r |=> con_seen_r)
        else $error("console mark lost");
    a_con_once: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        con_seen_r && !fell_edge(term_r) |=> !o_nmi)
        else $error("second console nmi");
endmodule
`default_nettype wire

//--- verif/drs_host_model.sv
// Host side model: interrupt acknowledge and bus hold grant.
// Assumes the bench commands acknowledge cycles at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module drs_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_ack_cycle,
    input  wire logic i_hold_req,
    output logic      o_int_ack_n,
    output logic      o_hold_grant
);
    // ****
    // Host bus
    // ****
    // Acknowledge stays low for the whole commanded cycle
    assign o_int_ack_n = ~i_ack_cycle;
    // Grant answers a hold request; host DMA channels are never claimed
    always_ff @(negedge i_clk_sys or posedge i_rst) begin
        if (i_rst) o_hold_grant <= 1'h0;
        else o_hold_grant <= i_hold_req;
    end
endmodule
`default_nettype wire

//--- verif/tb_dma_request_steering_glue.sv
// Bench for the steering glue: random straps, requests and serial lines.
// Assumes the host model beside it; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_dma_request_steering_glue;
    import drs_pkg::*;
    typedef struct packed {
        drs_req_t   dma;
        logic       nmi;
        logic [3:0] pas;
    } drs_exp_t;
    logic       clk, rst, ack, hreq, msel_n, mem_n, term, con, chain_n;
    logic       dz, d1, ctl_n, ram_n, nmi, hint, hold, ack_n, grant;
    logic [5:0] req;
    logic [1:0] pend, nmi_p;
    logic       prev_tx, prev_t, prev_c, con_seen;
    drs_steer_t steer;
    drs_exp_t   q[$];
    int         failures = 0, n_checks = 0, seed_v;
    drs_glue DUT (.i_clk_sys(clk), .i_rst(rst), .i_src_req_n(req),
        .i_steer(steer), .i_int_ack_n(ack_n), .i_bus_hold_req(hreq),
        .i_bus_hold_grant(grant), .i_midrange_select_two_n(msel_n),
        .i_mem_sel_n(mem_n), .i_term_rxd(term), .i_con_txd(con),
        .i_int_chain_req_n(chain_n), .o_dma_request_ch_zero(dz),
        .o_dma_request_ch_one(d1), .o_ctrl_reset_n(ctl_n),
        .o_ram_sel_n(ram_n), .o_nmi(nmi), .o_host_int(hint),
        .o_hold_req(hold));
    drs_host_model host (.i_clk_sys(clk), .i_rst(rst), .i_ack_cycle(ack),
        .i_hold_req(hold), .o_int_ack_n(ack_n), .o_hold_grant(grant));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic clear();
        {req, ack, term, con, pend, nmi_p} = {6'h3F, 1'h0, 2'h3, 4'h0};
        {prev_tx, prev_t, prev_c, con_seen} = 4'hE;
        {hreq, msel_n, mem_n, chain_n} = 4'h7;
    endtask
    // Pipeline depths: requests 2 edges, copies 1, start bits 2
    task automatic step();
        logic nw, tx;
        @(negedge clk);
        // One source low at a time, held a few cycles
        if (($urandom % 4) == 0)
            req = 6'h3F ^ (6'($urandom % 2) << ($urandom % 6));
        ack = ($urandom % 8) == 0;
        {hreq, msel_n, mem_n, chain_n, term, con} = 6'($urandom);
        q.push_back('{pend, nmi_p[0], {hreq, mem_n, msel_n, ~chain_n}});
        nw = (prev_t & ~term) | (prev_c & ~con & ~con_seen);
        con_seen |= prev_c & ~con;
        tx = (steer.dsc_tx_sel == DRS_TXS_DIRECT) ? ~req[1] : 1'h0;
        if (steer.dsc_tx_sel == DRS_TXS_CLIPPED) tx = ~req[1] & prev_tx;
        pend = ack ? 2'h0 : {|(~req & steer.en_ch_zero),
                             |(~req & steer.en_ch_one) | tx};
        {prev_tx, prev_t, prev_c} = {req[1], term, con};
        nmi_p = {nmi_p[0], nw};
    endtask
    always @(posedge clk) begin
        drs_exp_t e;
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            `CHK("dma", e.dma, {dz, d1})
            `CHK("nmi", e.nmi, nmi)
            `CHK("pass", e.pas, {hold, ram_n, ctl_n, hint})
        end
    end
    task automatic stop_test();
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        seed_v = $urandom(19050);
        rst = 1'h1;
        for (int p = 0; p < 6; p++) begin
            clear();
            // Straps move only in reset; bit 1 reaches channel one only via the selector
            steer = '{6'($urandom) & 6'h3D, 6'($urandom) & 6'h3D,
                      drs_txsel_t'(p % 3)};
            repeat (p == 0 ? 20 : 2) @(negedge clk);
            rst = 1'h0;
            repeat (300) step();
            for (int i = 0; i < 4 && q.size() > 0; i++) @(negedge clk);
            if (q.size() > 0) begin
                failures++;
                stop_test();
            end
            @(negedge clk);
            rst = 1'h1;
        end
        stop_test();
    end
endmodule
`default_nettype wire
